/* design/lt_frame_collect.sv */
`timescale 1ns/100ps
`default_nettype none

// pairs the two control words of one training frame; a frame only
// completes when the second word arrives after a first word
module lt_frame_collect (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic word_valid,
  input wire logic word_first,
  input wire logic [15:0] word_data,
  output logic frame_done,
  output logic [15:0] frame_word0,
  output logic [15:0] frame_word1
);

  typedef struct packed {
    logic have_first;
    logic done;
    logic [15:0] w0;
    logic [15:0] w0_hold;
    logic [15:0] w1;
  } coll_s;

  coll_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (word_valid) begin
      if (word_first) begin
        s_d.have_first = 1'b1;
        s_d.w0_hold = word_data;
      end else if (s_q.have_first) begin
        // publish both words in one step so readers never see a mix
        s_d.have_first = 1'b0;
        s_d.done = 1'b1;
        s_d.w0 = s_q.w0_hold;
        s_d.w1 = word_data;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '{1'b0, 1'b0, lt_partner_pkg::WORD_RESET, lt_partner_pkg::WORD_RESET, lt_partner_pkg::WORD_RESET};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign frame_done = s_q.done;
  assign frame_word0 = s_q.w0;
  assign frame_word1 = s_q.w1;

  // a frozen enable keeps done high, so only its rising edge is tied to the pending first word
  a_second_needs_first: assert property (@(posedge clock) disable iff (rst)
    $rose(frame_done) |-> $past(s_q.have_first))
    else $error("frame completed without first word");

  a_lone_second_ignored: assert property (@(posedge clock) disable iff (rst)
    clk_en && word_valid && !word_first && !s_q.have_first |=> !frame_done)
    else $error("second word without first word completed a frame");

endmodule

`default_nettype wire

/* design/lt_partner_pkg.sv */
package lt_partner_pkg;

  // field positions inside the 32-bit status word
  localparam int unsigned REQ_LSB = 16;
  localparam int unsigned REQ_MSB = 21;
  localparam int unsigned RPT_LSB = 24;
  localparam int unsigned RPT_MSB = 29;
  localparam int unsigned RDY_BIT = 30;

  // coefficient report subfield encodings
  localparam logic [1:0] COEF_NOT_UPDATED = 2'h0;
  localparam logic [1:0] COEF_MINIMUM = 2'h1;
  localparam logic [1:0] COEF_UPDATED = 2'h2;
  localparam logic [1:0] COEF_MAXIMUM = 2'h3;

  // coefficient change request encodings
  localparam logic [1:0] REQ_HOLD = 2'h0;
  localparam logic [1:0] REQ_INCREMENT = 2'h1;
  localparam logic [1:0] REQ_DECREMENT = 2'h2;

  // ready bit of the second training word and field width of both words
  localparam int unsigned WORD_RDY_BIT = 15;
  localparam int unsigned WORD_FIELD_W = 6;

  // reset values
  localparam logic [5:0] FIELD_RESET = 6'h00;
  localparam logic RDY_RESET = 1'b0;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // training words per frame
  localparam int unsigned FRAME_WORDS = 2;

endpackage

/* design/lt_partner_status.sv */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - six-bit read-only partner coefficient report in status bits 29:24 from word two
// - upper report subfield is post-tap: 11 max, 01 min, 10 updated, 00 not
// - bits 3:2 report centre tap, bits 1:0 report pre-tap, same encoding
// - read-only partner receiver-ready flag at bit 30, one when training done
// - ready low means partner wants training to continue; partner holds it low until ready
// - partner coefficient change request from word one shown read-only at bits 21:16
module lt_partner_status (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic word_valid,
  input wire logic word_first,
  input wire logic [15:0] word_data,
  output logic [31:0] status_word,
  output logic [5:0] partner_coef_state_report,
  output logic partner_rx_training_done,
  output logic [5:0] partner_coef_change_request,
  output logic [1:0] post_tap_state,
  output logic [1:0] centre_tap_state,
  output logic [1:0] pre_tap_state,
  output logic frame_update
);

  typedef struct packed {
    logic [5:0] report;
    logic rdy;
    logic [5:0] req;
    logic upd;
  } stat_s;

  stat_s s_q, s_d;
  logic frame_done;
  logic [15:0] w0;
  logic [15:0] w1;

  lt_frame_collect u_collect (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .word_valid(word_valid),
    .word_first(word_first),
    .word_data(word_data),
    .frame_done(frame_done),
    .frame_word0(w0),
    .frame_word1(w1)
  );

  // tap index 2 is post-tap, 1 centre, 0 pre-tap
  function automatic logic [1:0] subfield(input logic [5:0] f, input int unsigned idx);
    subfield = f[2*idx +: 2];
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.upd = 1'b0;
    if (frame_done) begin
      // one assignment point keeps the three fields coherent
      s_d.report = w1[lt_partner_pkg::WORD_FIELD_W-1:0];
      s_d.rdy = w1[lt_partner_pkg::WORD_RDY_BIT];
      s_d.req = w0[lt_partner_pkg::WORD_FIELD_W-1:0];
      s_d.upd = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '{lt_partner_pkg::FIELD_RESET, lt_partner_pkg::RDY_RESET, lt_partner_pkg::FIELD_RESET, 1'b0};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  always_comb begin
    // reserved bits read as zero
    status_word = 32'h0000_0000;
    status_word[lt_partner_pkg::RPT_MSB:lt_partner_pkg::RPT_LSB] = s_q.report;
    status_word[lt_partner_pkg::RDY_BIT] = s_q.rdy;
    status_word[lt_partner_pkg::REQ_MSB:lt_partner_pkg::REQ_LSB] = s_q.req;
  end

  assign partner_coef_state_report = s_q.report;
  // ready low is simply reported; the partner owns keeping it low
  assign partner_rx_training_done = s_q.rdy;
  assign partner_coef_change_request = s_q.req;
  assign post_tap_state = subfield(s_q.report, 2);
  assign centre_tap_state = subfield(s_q.report, 1);
  assign pre_tap_state = subfield(s_q.report, 0);
  assign frame_update = s_q.upd;

  // steps of one frame as the word inputs show it
  sequence first_taken;
    clk_en && word_valid && word_first;
  endsequence

  sequence second_taken;
    clk_en && word_valid && !word_first;
  endsequence

  sequence pair_taken;
    first_taken ##1 second_taken;
  endsequence

  // the collector needs one more enabled edge before the fields can move
  sequence pair_published;
    pair_taken ##1 clk_en;
  endsequence

  sequence frame_seen;
    clk_en && frame_done;
  endsequence

  // capture from the collector outputs
  a_report_capture: assert property (@(posedge clock) disable iff (rst)
    frame_seen |=> partner_coef_state_report == $past(w1[5:0]))
    else $error("report not captured");

  a_ready_capture: assert property (@(posedge clock) disable iff (rst)
    frame_seen |=> partner_rx_training_done == $past(w1[15]))
    else $error("ready flag not captured");

  a_request_capture: assert property (@(posedge clock) disable iff (rst)
    frame_seen |=> status_word[21:16] == $past(w0[5:0]))
    else $error("request not captured");

  // placement of every field inside the status word
  a_report_mirror: assert property (@(posedge clock) disable iff (rst)
    partner_coef_state_report == status_word[29:24])
    else $error("report field misplaced");

  a_post_tap_field: assert property (@(posedge clock) disable iff (rst)
    post_tap_state == status_word[29:28])
    else $error("post-tap subfield misplaced");

  a_centre_pre_fields: assert property (@(posedge clock) disable iff (rst)
    centre_tap_state == status_word[27:26] && pre_tap_state == status_word[25:24])
    else $error("tap subfields misplaced");

  a_tap_concat: assert property (@(posedge clock) disable iff (rst)
    {post_tap_state, centre_tap_state, pre_tap_state} == partner_coef_state_report)
    else $error("tap subfields out of order");

  a_ready_bit_pos: assert property (@(posedge clock) disable iff (rst)
    status_word[30] == partner_rx_training_done)
    else $error("ready flag misplaced");

  a_request_mirror: assert property (@(posedge clock) disable iff (rst)
    partner_coef_change_request == status_word[21:16])
    else $error("request field misplaced");

  // reserved bits stay low so software may compare whole words
  a_reserved_zero: assert property (@(posedge clock) disable iff (rst)
    status_word[31] == 1'b0 && status_word[23:22] == 2'h0 && status_word[15:0] == 16'h0000)
    else $error("reserved bits nonzero");

  // end to end walk: first word, second word, collector step, fields
  a_walk_update: assert property (@(posedge clock) disable iff (rst)
    pair_published |=> frame_update)
    else $error("frame did not publish");

  a_walk_report: assert property (@(posedge clock) disable iff (rst)
    pair_published |=> partner_coef_state_report == $past(word_data[5:0], 2))
    else $error("report differs from second word");

  a_walk_post_tap: assert property (@(posedge clock) disable iff (rst)
    pair_published |=> post_tap_state == $past(word_data[5:4], 2))
    else $error("post-tap state differs from second word");

  a_walk_low_taps: assert property (@(posedge clock) disable iff (rst)
    pair_published |=> {centre_tap_state, pre_tap_state} == $past(word_data[3:0], 2))
    else $error("centre or pre-tap state differs from second word");

  a_walk_ready: assert property (@(posedge clock) disable iff (rst)
    pair_published |=> partner_rx_training_done == $past(word_data[15], 2))
    else $error("ready flag differs from second word");

  a_walk_request: assert property (@(posedge clock) disable iff (rst)
    pair_published |=> partner_coef_change_request == $past(word_data[5:0], 3))
    else $error("request differs from first word");

  // pulse and hold behaviour; a frozen enable also freezes the pulse
  a_update_pulse: assert property (@(posedge clock) disable iff (rst)
    frame_seen |=> frame_update)
    else $error("update pulse missing");

  a_update_single: assert property (@(posedge clock) disable iff (rst)
    frame_update && clk_en |=> !frame_update)
    else $error("update pulse longer than one enabled cycle");

  a_no_stray_update: assert property (@(posedge clock) disable iff (rst)
    clk_en && !frame_done |=> !frame_update)
    else $error("update pulse without frame");

  a_update_cause: assert property (@(posedge clock) disable iff (rst)
    $rose(frame_update) |-> $past(frame_done))
    else $error("update pulse rose without collector");

  a_hold_between: assert property (@(posedge clock) disable iff (rst)
    !frame_seen |=> $stable(status_word))
    else $error("fields changed between frames");

  a_freeze_hold: assert property (@(posedge clock) disable iff (rst)
    !clk_en |=> $stable(status_word) && $stable(frame_update))
    else $error("state moved while enable low");

  a_change_flagged: assert property (@(posedge clock) disable iff (rst)
    $changed(status_word) |-> frame_update)
    else $error("fields changed without update pulse");

  a_ready_rise_flagged: assert property (@(posedge clock) disable iff (rst)
    $rose(partner_rx_training_done) |-> frame_update)
    else $error("ready flag rose outside a frame update");

endmodule

`default_nettype wire

/* test/lt_link_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module lt_link_partner (
  input wire logic clock,
  output logic word_valid,
  output logic word_first,
  output logic [15:0] word_data
);
  logic ready_q = 1'b0;
  initial word_valid = 1'b0;
  initial word_first = 1'b0;
  initial word_data = 16'h0000;
  // sticky: once done the receiver never asks for more training
  task automatic frame(input logic [5:0] q, input logic [5:0] r, input logic d, input logic lone, input logic twice);
    ready_q = ready_q | d;
    if (twice) begin
      // a stale first word that the real one must replace
      @(negedge clock);
      word_valid = 1'b1;
      word_first = 1'b1;
      word_data = {10'h000, ~q};
    end
    @(negedge clock);
    word_valid = !lone;
    word_first = 1'b1;
    word_data = {10'h000, q};
    @(negedge clock);
    word_valid = 1'b1;
    word_first = 1'b0;
    word_data = {ready_q, 9'h000, r};
    @(negedge clock);
    word_valid = 1'b0;
    word_data = ~word_data; // idle line shows no stale word
  endtask
endmodule
`default_nettype wire

/* test/lt_partner_status_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t mismatch %h != %h", $time, a, e); end end
module lt_partner_status_tb_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic word_valid, word_first, rdy_o, fu;
  logic [15:0] word_data;
  logic [31:0] status_word, held;
  logic [5:0] rpt_o, req_o;
  logic [1:0] post_o, cen_o, pre_o;
  int error_cnt = 0;
  int samples_checked = 0;
  integer seed = 32'h0dc6;
  logic rdy = 1'b0;
  initial forever #2.5 clock = ~clock;
  lt_link_partner lp (.clock(clock), .word_valid(word_valid), .word_first(word_first), .word_data(word_data));
  lt_partner_status uut (.clock(clock), .rst(rst), .clk_en(clk_en), .word_valid(word_valid),
    .word_first(word_first), .word_data(word_data), .status_word(status_word),
    .partner_coef_state_report(rpt_o), .partner_rx_training_done(rdy_o),
    .partner_coef_change_request(req_o), .post_tap_state(post_o), .centre_tap_state(cen_o),
    .pre_tap_state(pre_o), .frame_update(fu));
  function automatic logic [31:0] expect_word(logic [5:0] q, logic [5:0] r, logic d);
    return {1'b0, d, r, 2'h0, q, 16'h0000};
  endfunction
  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic send(input logic [5:0] q, input logic [5:0] r, input logic d, input logic lone, input logic twice);
    held = status_word;
    lp.frame(q, r, d, lone, twice);
    rdy = rdy | d;
    @(negedge clock);
    if (lone || !clk_en) begin
      `CHK({fu, status_word}, {1'b0, held})
    end else begin
      `CHK(status_word, expect_word(q, r, rdy))
      `CHK({fu, rpt_o, rdy_o, req_o}, {1'b1, r, rdy, q})
      `CHK({post_o, cen_o, pre_o}, r)
    end
    held = status_word;
    @(negedge clock);
    `CHK({fu, status_word}, {1'b0, held})
  endtask
  initial begin
    repeat (4) @(negedge clock);
    rst = 1'b0;
    `CHK({fu, status_word}, 33'h0)
    for (int k = 0; k < 4; k++) send(6'(k), {2'(k), 2'(k + 1), 2'(k + 2)}, 1'b0, 1'b0, 1'b0);
    $display("encodings done");
    send(6'h15, 6'h2a, 1'b0, 1'b1, 1'b0);
    send(6'h0c, 6'h33, 1'b0, 1'b0, 1'b1);
    clk_en = 1'b0;
    send(6'h3f, 6'h3f, 1'b0, 1'b0, 1'b0);
    clk_en = 1'b1;
    $display("refusals done");
    for (int i = 0; i < 30; i++) send(6'($random(seed)), 6'($random(seed)), i > 20, 1'b0, 1'($random(seed)));
    $display("random done");
    @(negedge clock);
    rst = 1'b1;
    @(negedge clock);
    `CHK({fu, status_word}, 33'h0)
    `CHK({rdy_o, rpt_o, req_o, post_o, cen_o, pre_o}, 19'h0)
    rst = 1'b0;
    send(6'h2d, 6'h12, 1'b0, 1'b0, 1'b0);
    $display("reset done");
    conclude();
  end
  initial begin
    #5000;
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
